// file: design/ccppw_timebase.sv
// Functional notes
// - each channel has its own timer select
// - period is (period+1) times 4 times prescale
// - timer clears on increment after period match
// - pin set at rollover unless duty zero
// - duty copied to internal buffer at rollover
// - postscaler never affects pwm period
// - format clear: right-justified duty bits
// - format set: left-justified duty bits
// - duty writes act only after next rollover
// - time base extends count with two bits
// - pin cleared when time base equals buffer
// - duty ratio is duty over 4(period+1)
// - select 00/01/10 timers, 11 reserved
//
// Local design decisions: the strobed register port and the address map.
`timescale 1ns/100ps
`default_nettype none
module ccppw_timebase (
  input  wire logic       i_clock,   // system clock, 125 MHz
  input  wire logic       i_arst_n,  // async reset, active low
  input  wire logic [5:0] i_addr,    // register address
  input  wire logic [7:0] i_wdata,   // write data
  input  wire logic       i_wr,      // write strobe
  input  wire logic       i_rd,      // read strobe
  output logic      [7:0] o_rdata,   // read data, cycle after read strobe
  output logic      [3:0] o_pwm      // compare unit output pins
);
  localparam int NCH = ccppw_pkg::NUM_CH;      // channel count
  localparam int NTM = ccppw_pkg::NUM_TIMERS;  // timer count

  // software visible state
  logic [7:0] tsel_reg;              // pwm_timer_source_select
  logic [7:0] period_reg  [NTM];     // timer_period_reg per timer
  logic [7:0] tctrl_reg   [NTM];     // timer run, prescale, postscale
  logic [7:0] duty_hi_reg [NCH];     // duty_value_high_byte
  logic [7:0] duty_lo_reg [NCH];     // duty_value_low_byte
  logic [NCH-1:0] ch_en_reg;         // channel enable
  logic [NCH-1:0] ch_fmt_reg;        // duty_alignment_format
  // hardware state
  logic [9:0] duty_buf_reg [NCH];    // latched duty used for compare
  logic [NCH-1:0] pwm_reg;           // output pin levels
  logic [7:0] rdata_reg;             // read data holding flop

  // timer outputs
  logic [7:0] tmr_count [NTM];       // counts
  logic [9:0] tmr_tb    [NTM];       // 10-bit time bases
  logic [NTM-1:0] tmr_roll;          // rollover pulses

  // per channel derived signals
  logic [9:0] duty_w   [NCH];        // duty assembled from byte pair
  logic [9:0] ch_tb    [NCH];        // selected time base
  logic [7:0] ch_pr    [NCH];        // selected period value
  logic [NCH-1:0] ch_roll;           // selected rollover
  logic [NCH-1:0] ch_valid;          // select field not reserved
  logic [NCH-1:0] ch_match;          // time base equals buffer
  logic [NCH-1:0] pwm_next;          // next pin level
  logic [10:0] ch_limit [NCH];       // 4*(period+1), one period in ticks

  // duty bit placement by format
  function automatic logic [9:0] assemble_duty(input logic fmt, input logic [7:0] hi,
                                               input logic [7:0] lo);
    if (fmt)
      assemble_duty = {hi, lo[7:6]};   // left-justified
    else
      assemble_duty = {hi[1:0], lo};   // right-justified
  endfunction

  // the timers themselves
  genvar t;
  generate
    for (t = 0; t < NTM; t++) begin : g_tmr
      ccppw_timer u_timer (
        .i_clock    (i_clock),
        .i_arst_n   (i_arst_n),
        .i_enable   (tctrl_reg[t][ccppw_pkg::TCTRL_EN_BIT]),
        .i_period   (period_reg[t]),
        .i_prescale (tctrl_reg[t][ccppw_pkg::TCTRL_PSC_LSB +: 2]),
        .o_count    (tmr_count[t]),
        .o_timebase (tmr_tb[t]),
        .o_rollover (tmr_roll[t])
      );
    end
  endgenerate

  // address decode
  wire       wr_tsel   = i_wr && (i_addr == ccppw_pkg::OFS_TSEL);
  wire       ch_region = i_addr[5:4] == ccppw_pkg::CH_REGION;  // channel block
  wire [1:0] ch_idx    = i_addr[3:2];                          // channel number
  wire [1:0] ch_sub    = i_addr[1:0];                          // register in channel
  logic [NTM-1:0] wr_period;   // period write hits
  logic [NTM-1:0] wr_tctrl;    // timer control write hits
  logic [NCH-1:0] wr_hi;       // duty high write hits
  logic [NCH-1:0] wr_lo;       // duty low write hits
  logic [NCH-1:0] wr_ctrl;     // channel control write hits

  generate
    for (t = 0; t < NTM; t++) begin : g_tdec
      assign wr_period[t] = i_wr && (i_addr == ccppw_pkg::OFS_PERIOD0 + 6'(t));
      assign wr_tctrl[t]  = i_wr && (i_addr == ccppw_pkg::OFS_TCTRL0 + 6'(t));
    end
  endgenerate

  // channel logic
  genvar c;
  generate
    for (c = 0; c < NCH; c++) begin : g_ch
      wire chan_hit = i_wr && ch_region && (ch_idx == 2'(c));
      wire [1:0] sel = tsel_reg[2*c +: 2];  // own field per channel
      assign wr_hi[c]   = chan_hit && (ch_sub == ccppw_pkg::CH_HI);
      assign wr_lo[c]   = chan_hit && (ch_sub == ccppw_pkg::CH_LO);
      assign wr_ctrl[c] = chan_hit && (ch_sub == ccppw_pkg::CH_CTRL);
      // 00 first, 01 second, 10 third timer; 11 has no time base
      assign ch_valid[c] = sel != ccppw_pkg::TSEL_RESERVED;
      assign ch_tb[c]    = (sel == 2'h0) ? tmr_tb[0] : (sel == 2'h1) ? tmr_tb[1] : tmr_tb[2];
      assign ch_pr[c]    = (sel == 2'h0) ? period_reg[0] :
                           (sel == 2'h1) ? period_reg[1] : period_reg[2];
      assign ch_roll[c]  = ch_valid[c] && ((sel == 2'h0) ? tmr_roll[0] :
                           (sel == 2'h1) ? tmr_roll[1] : tmr_roll[2]);
      assign duty_w[c]   = assemble_duty(ch_fmt_reg[c], duty_hi_reg[c], duty_lo_reg[c]);
      assign ch_limit[c] = {({1'b0, ch_pr[c]} + 9'h001), 2'b00};
      // equality only: a buffer past the period never matches, pin stays high
      assign ch_match[c] = ch_tb[c] == duty_buf_reg[c];
      // disabled or reserved select holds the pin low
      assign pwm_next[c] = (!ch_en_reg[c] || !ch_valid[c]) ? 1'b0 :
                           ch_roll[c] ? (duty_w[c] != 10'h000) :
                           ch_match[c] ? 1'b0 :
                           pwm_reg[c];

      // assertions for this channel
      a_roll_high: assert property (@(posedge i_clock) disable iff (!i_arst_n)
        ch_en_reg[c] && ch_roll[c] && duty_w[c] != 10'h000 |=> pwm_reg[c])
        else $error("pin not set at rollover");
      a_zero_low: assert property (@(posedge i_clock) disable iff (!i_arst_n)
        ch_en_reg[c] && ch_roll[c] && duty_w[c] == 10'h000 |=> !pwm_reg[c] [*2])
        else $error("pin set with zero duty");
      a_buffer_load: assert property (@(posedge i_clock) disable iff (!i_arst_n)
        ch_en_reg[c] && ch_roll[c] |=> duty_buf_reg[c] == $past(duty_w[c]))
        else $error("duty not latched at rollover");
      a_buffer_hold: assert property (@(posedge i_clock) disable iff (!i_arst_n)
        !ch_roll[c] |=> $stable(duty_buf_reg[c]))
        else $error("duty buffer changed between rollovers");
      a_fmt_right: assert property (@(posedge i_clock) disable iff (!i_arst_n)
        ch_en_reg[c] && ch_roll[c] && !ch_fmt_reg[c]
        |=> duty_buf_reg[c] == {$past(duty_hi_reg[c][1:0]), $past(duty_lo_reg[c])})
        else $error("right-justified duty misplaced");
      a_fmt_left: assert property (@(posedge i_clock) disable iff (!i_arst_n)
        ch_en_reg[c] && ch_roll[c] && ch_fmt_reg[c]
        |=> duty_buf_reg[c] == {$past(duty_hi_reg[c]), $past(duty_lo_reg[c][7:6])})
        else $error("left-justified duty misplaced");
      a_match_clear: assert property (@(posedge i_clock) disable iff (!i_arst_n)
        ch_en_reg[c] && !ch_roll[c] && ch_tb[c] == duty_buf_reg[c] |=> !pwm_reg[c])
        else $error("pin not cleared at duty match");
      a_full_high: assert property (@(posedge i_clock) disable iff (!i_arst_n)
        ch_en_reg[c] && ch_valid[c] && !ch_roll[c] && pwm_reg[c]
        && {1'b0, duty_buf_reg[c]} >= ch_limit[c] |=> pwm_reg[c])
        else $error("pin dropped with duty past period");
      a_tsel_reserved: assert property (@(posedge i_clock) disable iff (!i_arst_n)
        !ch_valid[c] |-> !ch_roll[c] ##1 !pwm_reg[c])
        else $error("reserved select drove the pin");

      c_roll_set: cover property (@(posedge i_clock) disable iff (!i_arst_n)
        ch_roll[c] && ch_en_reg[c] ##1 pwm_reg[c]);
      c_match_drop: cover property (@(posedge i_clock) disable iff (!i_arst_n)
        pwm_reg[c] && ch_match[c] && !ch_roll[c] ##1 !pwm_reg[c]);
      c_full_period: cover property (@(posedge i_clock) disable iff (!i_arst_n)
        pwm_reg[c] && {1'b0, duty_buf_reg[c]} >= ch_limit[c] ##1 ch_roll[c]);
      c_left_load: cover property (@(posedge i_clock) disable iff (!i_arst_n)
        ch_roll[c] && ch_fmt_reg[c] && ch_en_reg[c]);
    end
  endgenerate

  // timer source select, reset to zero so all channels start on the first timer
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n)
      tsel_reg <= ccppw_pkg::RST_BYTE;
    else if (wr_tsel)
      tsel_reg <= i_wdata;
  end

  // timer period and control; software must start a timer before use
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      for (int i = 0; i < NTM; i++) begin
        period_reg[i] <= ccppw_pkg::RST_PERIOD;
        tctrl_reg[i]  <= ccppw_pkg::RST_BYTE;
      end
    end else begin
      for (int i = 0; i < NTM; i++) begin
        if (wr_period[i])
          period_reg[i] <= i_wdata;
        if (wr_tctrl[i])
          tctrl_reg[i] <= i_wdata & ccppw_pkg::TCTRL_MASK;  // postscale kept, unused
      end
    end
  end

  // duty byte pair and channel control; writes land any time
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ch_en_reg  <= '0;
      ch_fmt_reg <= '0;
      for (int i = 0; i < NCH; i++) begin
        duty_hi_reg[i] <= ccppw_pkg::RST_BYTE;
        duty_lo_reg[i] <= ccppw_pkg::RST_BYTE;
      end
    end else begin
      for (int i = 0; i < NCH; i++) begin
        if (wr_hi[i])
          duty_hi_reg[i] <= i_wdata;
        if (wr_lo[i])
          duty_lo_reg[i] <= i_wdata;
        if (wr_ctrl[i]) begin
          ch_en_reg[i]  <= i_wdata[ccppw_pkg::CTRL_EN_BIT];
          ch_fmt_reg[i] <= i_wdata[ccppw_pkg::CTRL_FMT_BIT];
        end
      end
    end
  end

  // compare buffer reloads only at rollover, which keeps the output glitch free
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      for (int i = 0; i < NCH; i++)
        duty_buf_reg[i] <= 10'h000;
    end else begin
      for (int i = 0; i < NCH; i++)
        if (ch_roll[i] && ch_en_reg[i])
          duty_buf_reg[i] <= duty_w[i];
    end
  end

  // pin levels
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n)
      pwm_reg <= '0;
    else
      pwm_reg <= pwm_next;
  end

  // read mux; unmapped and reserved bits read as zero
  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = 8'h00;
    if (i_addr == ccppw_pkg::OFS_TSEL)
      rd_mux = tsel_reg;
    for (int i = 0; i < NTM; i++) begin
      if (i_addr == ccppw_pkg::OFS_PERIOD0 + 6'(i))
        rd_mux = period_reg[i];
      if (i_addr == ccppw_pkg::OFS_TCTRL0 + 6'(i))
        rd_mux = tctrl_reg[i];
      if (i_addr == ccppw_pkg::OFS_TCOUNT0 + 6'(i))
        rd_mux = tmr_count[i];
    end
    if (ch_region) begin
      unique case (ch_sub)
        ccppw_pkg::CH_HI:   rd_mux = duty_hi_reg[ch_idx];
        ccppw_pkg::CH_LO:   rd_mux = duty_lo_reg[ch_idx];
        ccppw_pkg::CH_CTRL: rd_mux = {3'h0, ch_fmt_reg[ch_idx], 3'h0, ch_en_reg[ch_idx]};
        ccppw_pkg::CH_STAT: rd_mux = {7'h00, pwm_reg[ch_idx]};
      endcase
    end
  end

  // read data stands for one cycle only, zero otherwise
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n)
      rdata_reg <= 8'h00;
    else
      rdata_reg <= i_rd ? rd_mux : 8'h00;
  end

  assign o_rdata = rdata_reg;
  assign o_pwm   = pwm_reg;
endmodule // ccppw_timebase
`default_nettype wire

// file: design/ccppw_pkg.sv
package ccppw_pkg;
  // bus geometry
  localparam int ADDR_W     = 6;     // register address width
  localparam int DATA_W     = 8;     // register data width
  localparam int TMR_W      = 8;     // auto-reload timer width
  localparam int DUTY_W     = 10;    // duty value and time base width
  localparam int NUM_TIMERS = 3;     // selectable time bases
  localparam int NUM_CH     = 4;     // pwm channels
  localparam int TSEL_W     = 2;     // timer select field width
  localparam int PRE_W      = 6;     // prescaler counter width

  // register offsets
  localparam logic [5:0] OFS_TSEL    = 6'h00;  // timer source select
  localparam logic [5:0] OFS_PERIOD0 = 6'h01;  // timer periods at 01..03
  localparam logic [5:0] OFS_TCTRL0  = 6'h04;  // timer controls at 04..06
  localparam logic [5:0] OFS_TCOUNT0 = 6'h07;  // timer counts at 07..09, read only
  localparam logic [1:0] CH_REGION   = 2'h1;   // addr[5:4] of channel block
  localparam logic [1:0] CH_HI       = 2'h0;   // duty high byte
  localparam logic [1:0] CH_LO       = 2'h1;   // duty low byte
  localparam logic [1:0] CH_CTRL     = 2'h2;   // channel control
  localparam logic [1:0] CH_STAT     = 2'h3;   // channel status, read only

  // fields
  localparam int CTRL_EN_BIT    = 0;   // channel enable
  localparam int CTRL_FMT_BIT   = 4;   // duty alignment format
  localparam int TCTRL_EN_BIT   = 0;   // timer run
  localparam int TCTRL_PSC_LSB  = 1;   // prescale code, 2 bits
  localparam logic [7:0] CTRL_MASK  = 8'h11;  // implemented channel control bits
  localparam logic [7:0] TCTRL_MASK = 8'h7f;  // en, prescale, postscale
  localparam logic [1:0] TSEL_RESERVED = 2'h3;  // no time base

  // prescale codes
  localparam logic [1:0] PSC_1  = 2'h0;
  localparam logic [1:0] PSC_4  = 2'h1;
  localparam logic [1:0] PSC_16 = 2'h2;
  localparam logic [1:0] PSC_64 = 2'h3;
  localparam logic [5:0] PRE_MAX_1  = 6'h00;
  localparam logic [5:0] PRE_MAX_4  = 6'h03;
  localparam logic [5:0] PRE_MAX_16 = 6'h0f;
  localparam logic [5:0] PRE_MAX_64 = 6'h3f;

  // system clocks per instruction cycle, last phase index
  localparam logic [1:0] PHASE_LAST = 2'h3;

  // reset values
  localparam logic [7:0] RST_BYTE   = 8'h00;
  localparam logic [7:0] RST_PERIOD = 8'hff;
endpackage

// file: design/ccppw_timer.sv
`timescale 1ns/100ps
`default_nettype none
module ccppw_timer (
  input  wire logic       i_clock,      // system clock
  input  wire logic       i_arst_n,     // async reset, active low
  input  wire logic       i_enable,     // timer run
  input  wire logic [7:0] i_period,     // period match value
  input  wire logic [1:0] i_prescale,   // prescale code
  output logic      [7:0] o_count,      // timer count
  output logic      [9:0] o_timebase,   // count extended by two low bits
  output logic            o_rollover    // one-cycle pulse at period start
);
  logic [1:0] phase_reg;   // system clock phase in instruction cycle
  logic [5:0] pre_reg;     // prescaler count of instruction cycles
  logic [7:0] count_reg;   // auto-reload count
  logic       roll_reg;    // rollover pulse

  // prescaler terminal count per code
  function automatic logic [5:0] pre_max(input logic [1:0] code);
    unique case (code)
      ccppw_pkg::PSC_1:  pre_max = ccppw_pkg::PRE_MAX_1;
      ccppw_pkg::PSC_4:  pre_max = ccppw_pkg::PRE_MAX_4;
      ccppw_pkg::PSC_16: pre_max = ccppw_pkg::PRE_MAX_16;
      ccppw_pkg::PSC_64: pre_max = ccppw_pkg::PRE_MAX_64;
    endcase
  endfunction

  wire       inst_tick = i_enable && (phase_reg == ccppw_pkg::PHASE_LAST);  // fosc/4 edge
  wire       pre_wrap  = pre_reg >= pre_max(i_prescale);  // >= survives code changes
  wire       inc       = inst_tick && pre_wrap;            // timer increment
  wire       at_period = count_reg == i_period;            // match with period value
  wire [5:0] pre_next  = inst_tick ? (pre_wrap ? 6'h00 : pre_reg + 6'h01) : pre_reg;
  wire [7:0] cnt_next  = inc ? (at_period ? 8'h00 : count_reg + 8'h01) : count_reg;
  wire [1:0] phase_next = i_enable ? phase_reg + 2'h1 : 2'h0;

  // low time base bits: clock phase at 1:1, else the top prescaler bits of the range
  logic [1:0] ext_bits;
  always_comb begin
    unique case (i_prescale)
      ccppw_pkg::PSC_1:  ext_bits = phase_reg;
      ccppw_pkg::PSC_4:  ext_bits = pre_reg[1:0];
      ccppw_pkg::PSC_16: ext_bits = pre_reg[3:2];
      ccppw_pkg::PSC_64: ext_bits = pre_reg[5:4];
    endcase
  end

  // period is (period+1) * 4 clocks * prescale; no postscaler in this path
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      phase_reg <= 2'h0;
      pre_reg   <= 6'h00;
      count_reg <= 8'h00;
      roll_reg  <= 1'b0;
    end else begin
      phase_reg <= phase_next;
      pre_reg   <= pre_next;
      count_reg <= cnt_next;
      roll_reg  <= inc && at_period;
    end
  end

  assign o_count    = count_reg;
  assign o_timebase = {count_reg, ext_bits};
  assign o_rollover = roll_reg;

  a_timer_wrap: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    inc && at_period |=> count_reg == 8'h00 && roll_reg)
    else $error("timer did not clear after period match");
endmodule // ccppw_timer
`default_nettype wire

// file: verification/ccppw_pin_load.sv
`timescale 1ns/100ps
`default_nettype none
// stands where the pins go: a pure load that never drives back, only measures
module ccppw_pin_load (
  input  wire logic             i_clock,      // system clock
  input  wire logic             i_arst_n,     // async reset, active low
  input  wire logic [3:0]       i_pwm,        // pins under observation
  input  wire logic             i_clear,      // restart the high-time totals
  output logic      [3:0][15:0] o_high_len,   // high cycles of last whole period
  output logic      [3:0][15:0] o_per_len,    // cycles between last two rises
  output logic      [3:0][15:0] o_high_total, // high cycles since clear
  output logic      [3:0][15:0] o_rises       // rising edges seen
);
  logic [3:0]       prev_reg;  // pin level one cycle back
  logic [3:0][15:0] hi_run;    // high cycles in running period
  logic [3:0][15:0] per_run;   // cycles in running period

  // measure per channel; the first period after enable is junk, callers skip it
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      prev_reg     <= '0;
      hi_run       <= '0;
      per_run      <= '0;
      o_high_len   <= '0;
      o_per_len    <= '0;
      o_high_total <= '0;
      o_rises      <= '0;
    end else begin
      prev_reg <= i_pwm;
      for (int c = 0; c < 4; c++) begin
        o_high_total[c] <= i_clear ? 16'h0000 : o_high_total[c] + {15'h0000, i_pwm[c]};
        if (i_pwm[c] && !prev_reg[c]) begin
          // a rise closes the previous period
          o_high_len[c] <= hi_run[c];
          o_per_len[c]  <= per_run[c];
          hi_run[c]     <= 16'h0001;
          per_run[c]    <= 16'h0001;
          o_rises[c]    <= o_rises[c] + 16'h0001;
        end else begin
          hi_run[c]  <= hi_run[c] + {15'h0000, i_pwm[c]};
          per_run[c] <= per_run[c] + 16'h0001;
        end
      end
    end
  end
endmodule // ccppw_pin_load
`default_nettype wire

// file: verification/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic             i_clock = 1'b0;  // 125 MHz system clock
  logic             i_arst_n;     // async reset, active low
  logic [5:0]       i_addr;       // register address
  logic [7:0]       i_wdata;      // write data
  logic             i_wr;         // write strobe
  logic             i_rd;         // read strobe
  logic [7:0]       o_rdata;      // read data
  logic [3:0]       o_pwm;        // pins
  logic             load_clear;   // restart load totals
  logic [3:0][15:0] high_len;     // last high width
  logic [3:0][15:0] per_len;      // last period
  logic [3:0][15:0] high_total;   // high cycles since clear
  logic [3:0][15:0] rises;        // rise counts
  int               num_errors;   // mismatches
  int               check_count;  // comparisons

  ccppw_timebase u_dut (.i_clock(i_clock), .i_arst_n(i_arst_n), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_pwm(o_pwm));

  ccppw_pin_load u_load (.i_clock(i_clock), .i_arst_n(i_arst_n), .i_pwm(o_pwm),
    .i_clear(load_clear), .o_high_len(high_len), .o_per_len(per_len),
    .o_high_total(high_total), .o_rises(rises));

  // free running clock
  always #4 i_clock = ~i_clock;

  // verdict and stop, shared by the main flow and every timeout
  task automatic end_of_test();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // tolerance covers the register latency on pulse edges only
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input logic [15:0] tol);
    check_count++;
    if (^seen === 1'bx || ((seen > exp) ? seen - exp : exp - seen) > tol) begin
      num_errors++;
      $display("CHECK FAILED at %0t: saw %0d expected %0d", $time, seen, exp);
    end
  endtask

  // one-cycle write strobe
  task automatic bus_write(input logic [5:0] a, input logic [7:0] d);
    @(posedge i_clock);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= d;
    @(posedge i_clock);
    i_wr    <= 1'b0;
  endtask

  // one-cycle read strobe, data stands only in the next cycle
  task automatic rd_check(input logic [5:0] a, input logic [7:0] exp);
    @(posedge i_clock);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_clock);
    i_rd   <= 1'b0;
    #1;
    check({8'h00, o_rdata}, {8'h00, exp}, 16'h0000);
  endtask

  // bounded wait for n new rises on a channel
  task automatic wait_rises(input int c, input int n);
    logic [15:0] start;
    int          k;
    start = rises[c];
    k = 0;
    while (rises[c] - start < n[15:0] && k < 3000) begin
      @(posedge i_clock);
      #1;
      k++;
    end
    if (k == 3000) begin
      num_errors++;
      $display("CHECK FAILED at %0t: no pulse on channel %0d", $time, c);
      end_of_test();
    end
  endtask

  // cleared window of fixed length, then high totals
  task automatic window(input int cycles);
    @(posedge i_clock);
    load_clear <= 1'b1;
    @(posedge i_clock);
    load_clear <= 1'b0;
    repeat (cycles) @(posedge i_clock);
    #1;
  endtask

  initial begin
    i_arst_n = 1'b0;
    i_addr = 6'h00;
    i_wdata = 8'h00;
    i_wr = 1'b0; i_rd = 1'b0; load_clear = 1'b0; num_errors = 0; check_count = 0;
    repeat (8) @(posedge i_clock);
    i_arst_n <= 1'b1;
    // reset values, unmapped and read-only places
    rd_check(6'h00, 8'h00);
    rd_check(6'h01, 8'hff);
    rd_check(6'h0a, 8'h00);
    bus_write(6'h07, 8'h55);
    rd_check(6'h07, 8'h00);
    // periods 4, 9, 2; channel c on timer c, last one reserved
    bus_write(6'h01, 8'h04);
    bus_write(6'h02, 8'h09);
    bus_write(6'h03, 8'h02);
    bus_write(6'h00, 8'he4);
    rd_check(6'h00, 8'he4);
    // ch0 right-justified 10 with junk high bits, ch1 left-justified 21
    bus_write(6'h10, 8'hfc);
    bus_write(6'h11, 8'h0a);
    bus_write(6'h12, 8'h01);
    bus_write(6'h14, 8'h05);
    bus_write(6'h15, 8'h7f);
    bus_write(6'h16, 8'h11);
    bus_write(6'h18, 8'h00);
    bus_write(6'h19, 8'h05);
    bus_write(6'h1a, 8'h01);
    bus_write(6'h1c, 8'h00);
    bus_write(6'h1d, 8'h40);
    bus_write(6'h1e, 8'h01);
    // timer0 at 1:1 with postscale bits set, timer1 1:1, timer2 1:4
    bus_write(6'h04, 8'h79);
    bus_write(6'h05, 8'h01);
    bus_write(6'h06, 8'h03);
    for (int c = 0; c < 3; c++) wait_rises(c, 3);
    check(per_len[0], 16'h0014, 16'h0000);
    check(high_len[0], 16'h000a, 16'h0001);
    check(per_len[1], 16'h0028, 16'h0000);
    check(high_len[1], 16'h0015, 16'h0001);
    check(per_len[2], 16'h0030, 16'h0000);
    // duty 5 at 1:4: low time base bits follow the prescaler, not the clock phase
    check(high_len[2], 16'h0014, 16'h0001);
    rd_check(6'h1f, 8'h00);
    // duty change mid-period waits for the next rollover
    wait_rises(0, 1);
    bus_write(6'h11, 8'h06);
    wait_rises(0, 1);
    check(high_len[0], 16'h000a, 16'h0001);
    wait_rises(0, 1);
    check(high_len[0], 16'h0006, 16'h0001);
    // duty beyond the period keeps the pin high
    bus_write(6'h10, 8'h03);
    bus_write(6'h11, 8'hff);
    repeat (50) @(posedge i_clock);
    window(60);
    check(high_total[0], 16'h003c, 16'h0001);
    // zero duty on ch0 and the reserved select on ch3 never set the pin
    bus_write(6'h10, 8'h00);
    bus_write(6'h11, 8'h00);
    repeat (50) @(posedge i_clock);
    window(60);
    check(high_total[0], 16'h0000, 16'h0000);
    check(high_total[3], 16'h0000, 16'h0000);
    end_of_test();
  end
endmodule // tb
`default_nettype wire
